// ===== src/charger_defs.svh
// Constants for the charger status and configuration register pair.
// Assumes inclusion by bare name from the package and the design file.
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH

// Register addresses
`define REG_INREG_ADDR 8'h05
`define REG_TIMER_ADDR 8'h06

// Field positions in the input regulation register
`define INREG_MINSYS_BIT 7
`define INREG_VINREG_BIT 6
`define INREG_REDUCED_BIT 5
`define INREG_DETECT_BIT 4
`define INREG_DISABLE_BIT 3
`define INREG_CODE_HI 2
`define INREG_CODE_LO 0

// Field positions in the timer and thermistor register
`define TIMER_HALF_BIT 7
`define TIMER_SEL_HI 6
`define TIMER_SEL_LO 5
`define TIMER_BOOST_BIT 4
`define TIMER_THERM_EN_BIT 3
`define TIMER_FAULT_HI 2
`define TIMER_FAULT_LO 1
`define TIMER_BASE_BIT 0

// Reset values of writable fields
`define RST_REDUCED 1'h0
`define RST_DETECT 1'h0
`define RST_CODE 3'h0
`define RST_HALF 1'h1
`define RST_TIMER_SEL 2'h0
`define RST_BOOST 1'h1
`define RST_THERM_EN 1'h1
`define RST_BASE 1'h0

// Charge current in mA
`define CUR_REDUCED_MA 12'h12C
`define CUR_BASE_MA 12'h1F4
`define CUR_STEP_MA 12'h064
`define CUR_MAX_MA 12'hBB8

// Boost current limit in mA
`define BOOST_HIGH_MA 13'hFA0
`define BOOST_LOW_MA 13'h7D0

// Safety timer limits in seconds (1.25 min, 6 h, 9 h)
`define TMR_SHORT_S 17'h0004B
`define TMR_MID_S 17'h05460
`define TMR_LONG_S 17'h07E90

// Input threshold base in mV and the 2 percent divisor
`define VIN_BASE_LOW_MV 20'h01068
`define VIN_BASE_HIGH_MV 20'h02774
`define VIN_PCT_DIV 20'h00032

// Thermistor fault codes
`define FAULT_NORMAL 2'h0

`endif

// ===== src/charger_pkg.sv
// Types for the charger status and configuration register pair.
// Assumes the defines header sits on the include path.
`include "charger_defs.svh"

package charger_pkg;

   // One register access from the serial interface engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   // Live conditions from the analog and control core
   typedef struct packed {
      logic min_system_mode_flag;
      logic input_regulation_active_flag;
      logic chip_disable_pin;
      logic thermal_reg_active;
      logic input_current_limit_active;
      logic [1:0] thermistor_fault_code;
   } core_status_s;

   // Safety timer limit encodings
   typedef enum logic [1:0] {
      TMR_SEL_SHORT = 2'h0,
      TMR_SEL_MID = 2'h1,
      TMR_SEL_LONG = 2'h2,
      TMR_SEL_OFF = 2'h3
   } timer_sel_e;

endpackage

// ===== src/charger_status_config_regs.sv
// Input regulation status register and safety timer / thermistor register.
// Assumes a serial interface engine issues one access per cycle on i_req,
// and that the core supplies live status synchronous to i_mclk.
`timescale 1ns/100ps
`default_nettype none
`include "charger_defs.svh"

module charger_status_config_regs
   import charger_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire reg_req_s i_req,
   input wire core_status_s i_status,
   input wire logic [4:0] i_fast_charge_code,
   input wire logic i_detect_done,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   output logic o_detect_start,
   output logic [11:0] o_charge_current_ma,
   output logic [19:0] o_input_threshold_mv,
   output logic o_timer_halfspeed,
   output logic [16:0] o_timer_limit_s,
   output logic o_timer_disable,
   output logic [12:0] o_boost_limit_ma,
   output logic o_thermistor_enable
);

   logic reduced_current_select_ff;
   logic detect_ff;
   logic [2:0] input_threshold_code_ff;
   logic timer_halfspeed_enable_ff;
   timer_sel_e timer_sel_ff;
   logic boost_limit_select_ff;
   logic thermistor_enable_ff;
   logic input_threshold_base_select_ff;
   logic wr_inreg;
   logic wr_timer;
   logic [1:0] fault_view;
   logic [7:0] inreg_view;
   logic [7:0] timer_view;
   logic [7:0] nxt_rdata;
   logic [12:0] nxt_cur_sum;
   logic [19:0] nxt_threshold;

   assign wr_inreg = i_req.wr && (i_req.addr == `REG_INREG_ADDR);
   assign wr_timer = i_req.wr && (i_req.addr == `REG_TIMER_ADDR);

   // Fault code reads as normal while monitoring is off
   assign fault_view = thermistor_enable_ff ?
      i_status.thermistor_fault_code : `FAULT_NORMAL;

   // Read views: status bits are live, never stored from writes
   always_comb begin
      inreg_view = 8'h00;
      inreg_view[`INREG_MINSYS_BIT] = i_status.min_system_mode_flag;
      inreg_view[`INREG_VINREG_BIT] =
         i_status.input_regulation_active_flag;
      inreg_view[`INREG_REDUCED_BIT] = reduced_current_select_ff;
      inreg_view[`INREG_DETECT_BIT] = detect_ff;
      inreg_view[`INREG_DISABLE_BIT] = i_status.chip_disable_pin;
      inreg_view[`INREG_CODE_HI:`INREG_CODE_LO] = input_threshold_code_ff;
      timer_view = 8'h00;
      timer_view[`TIMER_HALF_BIT] = timer_halfspeed_enable_ff;
      timer_view[`TIMER_SEL_HI:`TIMER_SEL_LO] = timer_sel_ff;
      timer_view[`TIMER_BOOST_BIT] = boost_limit_select_ff;
      timer_view[`TIMER_THERM_EN_BIT] = thermistor_enable_ff;
      timer_view[`TIMER_FAULT_HI:`TIMER_FAULT_LO] = fault_view;
      timer_view[`TIMER_BASE_BIT] = input_threshold_base_select_ff;
   end

   // Read data mux; unmapped addresses read as zero
   always_comb begin
      unique case (i_req.addr)
         `REG_INREG_ADDR: nxt_rdata = inreg_view;
         `REG_TIMER_ADDR: nxt_rdata = timer_view;
         default: nxt_rdata = 8'h00;
      endcase
   end

   // Registered read answer one cycle after the request
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_req.rd;
         if (i_req.rd) begin
            o_reg_rdata <= nxt_rdata;
         end
      end
   end

   // Writable fields of the input regulation register
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         reduced_current_select_ff <= `RST_REDUCED;
         input_threshold_code_ff <= `RST_CODE;
      end else if (wr_inreg) begin
         reduced_current_select_ff <= i_req.wdata[`INREG_REDUCED_BIT];
         input_threshold_code_ff <=
            i_req.wdata[`INREG_CODE_HI:`INREG_CODE_LO];
      end
   end

   // Detection request: a write wins over completion in the same cycle
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         detect_ff <= `RST_DETECT;
         o_detect_start <= 1'b0;
      end else begin
         o_detect_start <= wr_inreg && i_req.wdata[`INREG_DETECT_BIT];
         if (wr_inreg) begin
            detect_ff <= i_req.wdata[`INREG_DETECT_BIT];
         end else if (i_detect_done) begin
            detect_ff <= 1'b0;
         end
      end
   end

   // Writable fields of the timer and thermistor register
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_halfspeed_enable_ff <= `RST_HALF;
         timer_sel_ff <= timer_sel_e'(`RST_TIMER_SEL);
         boost_limit_select_ff <= `RST_BOOST;
         thermistor_enable_ff <= `RST_THERM_EN;
         input_threshold_base_select_ff <= `RST_BASE;
      end else if (wr_timer) begin
         timer_halfspeed_enable_ff <= i_req.wdata[`TIMER_HALF_BIT];
         timer_sel_ff <=
            timer_sel_e'(i_req.wdata[`TIMER_SEL_HI:`TIMER_SEL_LO]);
         boost_limit_select_ff <= i_req.wdata[`TIMER_BOOST_BIT];
         thermistor_enable_ff <= i_req.wdata[`TIMER_THERM_EN_BIT];
         input_threshold_base_select_ff <=
            i_req.wdata[`TIMER_BASE_BIT];
      end
   end

   // Charge current and input threshold arithmetic
   always_comb begin
      nxt_cur_sum = {1'b0, `CUR_BASE_MA} +
         13'(i_fast_charge_code) * {1'b0, `CUR_STEP_MA};
      nxt_threshold = (input_threshold_base_select_ff ?
         `VIN_BASE_HIGH_MV : `VIN_BASE_LOW_MV) *
         (`VIN_PCT_DIV + 20'(input_threshold_code_ff)) /
         `VIN_PCT_DIV;
   end

   // Core controls, all from flip-flops
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_charge_current_ma <= `CUR_REDUCED_MA;
         o_input_threshold_mv <= `VIN_BASE_LOW_MV;
         o_timer_halfspeed <= 1'b0;
         o_timer_limit_s <= `TMR_SHORT_S;
         o_timer_disable <= 1'b0;
         o_boost_limit_ma <= `BOOST_HIGH_MA;
         o_thermistor_enable <= 1'b1;
      end else begin
         if (reduced_current_select_ff) begin
            o_charge_current_ma <= `CUR_REDUCED_MA;
         end else if (nxt_cur_sum > {1'b0, `CUR_MAX_MA}) begin
            o_charge_current_ma <= `CUR_MAX_MA;
         end else begin
            o_charge_current_ma <= nxt_cur_sum[11:0];
         end
         o_input_threshold_mv <= nxt_threshold;
         o_timer_halfspeed <= timer_halfspeed_enable_ff &&
            (i_status.thermal_reg_active ||
             i_status.input_regulation_active_flag ||
             i_status.input_current_limit_active);
         unique case (timer_sel_ff)
            TMR_SEL_SHORT: o_timer_limit_s <= `TMR_SHORT_S;
            TMR_SEL_MID: o_timer_limit_s <= `TMR_MID_S;
            TMR_SEL_LONG: o_timer_limit_s <= `TMR_LONG_S;
            TMR_SEL_OFF: o_timer_limit_s <= `TMR_LONG_S;
         endcase
         o_timer_disable <= (timer_sel_ff == TMR_SEL_OFF);
         o_boost_limit_ma <= boost_limit_select_ff ?
            `BOOST_HIGH_MA : `BOOST_LOW_MA;
         o_thermistor_enable <= thermistor_enable_ff;
      end
   end

   // Helper flags: no write yet since reset
   logic untouched5_ff;
   logic untouched6_ff;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         untouched5_ff <= 1'b1;
         untouched6_ff <= 1'b1;
      end else begin
         if (wr_inreg) untouched5_ff <= 1'b0;
         if (wr_timer) untouched6_ff <= 1'b0;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   sequence rd5_s;
      i_req.rd && i_req.addr == `REG_INREG_ADDR && !i_req.wr;
   endsequence
   sequence rd6_s;
      i_req.rd && i_req.addr == `REG_TIMER_ADDR && !i_req.wr;
   endsequence
   sequence wr5_set_s;
      wr_inreg && i_req.wdata[`INREG_DETECT_BIT];
   endsequence

   chk_minsys_read: assert property (rd5_s |=> o_reg_rvalid &&
      o_reg_rdata[7] == $past(i_status.min_system_mode_flag))
      else $error("minimum system flag misread");
   chk_vinreg_read: assert property (rd5_s |=>
      o_reg_rdata[6] == $past(i_status.input_regulation_active_flag))
      else $error("input regulation flag misread");
   chk_reduced_cur: assert property (reduced_current_select_ff &&
      $past(reduced_current_select_ff) |-> o_charge_current_ma == 12'h12C)
      else $error("reduced current not 300 mA");
   chk_detect_start: assert property (wr5_set_s |=> o_detect_start &&
      detect_ff ##1
      o_detect_start == $past(wr_inreg && i_req.wdata[`INREG_DETECT_BIT]))
      else $error("detection start pulse wrong");
   chk_detect_clear: assert property (detect_ff && i_detect_done &&
      !wr_inreg |=> !detect_ff)
      else $error("detection flag not cleared");
   chk_disable_read: assert property (rd5_s |=>
      o_reg_rdata[3] == $past(i_status.chip_disable_pin))
      else $error("disable pin level misread");
   chk_threshold_val: assert property (!wr_inreg && !wr_timer &&
      input_threshold_code_ff == 3'h7 && !input_threshold_base_select_ff
      |=> o_input_threshold_mv == 20'h012B4)
      else $error("input threshold wrong");
   chk_base_high: assert property (!wr_inreg && !wr_timer &&
      input_threshold_code_ff == 3'h0 && input_threshold_base_select_ff
      |=> o_input_threshold_mv == 20'h02774)
      else $error("high base wrong");
   chk_halfspeed_gate: assert property (!timer_halfspeed_enable_ff
      |=> !o_timer_halfspeed)
      else $error("timer slowed while disabled");
   chk_timer_mid: assert property (timer_sel_ff == TMR_SEL_MID &&
      !wr_timer |=> o_timer_limit_s == 17'h05460 && !o_timer_disable)
      else $error("six hour limit wrong");
   chk_boost_low: assert property (!boost_limit_select_ff &&
      !wr_timer |=> o_boost_limit_ma == 13'h07D0)
      else $error("boost limit wrong");
   chk_therm_en: assert property (##1 o_thermistor_enable ==
      $past(thermistor_enable_ff))
      else $error("thermistor enable not followed");
   chk_fault_read: assert property (rd6_s and thermistor_enable_ff
      |=> o_reg_rdata[2:1] == $past(i_status.thermistor_fault_code))
      else $error("fault code misread");
   chk_reset_inreg: assert property (untouched5_ff |->
      !reduced_current_select_ff && input_threshold_code_ff == 3'h0)
      else $error("input register reset value wrong");
   chk_reset_timer: assert property (rd6_s and untouched6_ff |=>
      o_reg_rdata[7:3] == 5'h13 && !o_reg_rdata[0])
      else $error("timer register reset value wrong");
   chk_cur_saturate: assert property (!reduced_current_select_ff &&
      $stable(reduced_current_select_ff) && i_fast_charge_code == 5'h1F
      |=> o_charge_current_ma == 12'hBB8)
      else $error("charge current not saturated");
   chk_status_wr: assert property (wr_inreg ##[1:2] rd5_s |=>
      o_reg_rdata[7] == $past(i_status.min_system_mode_flag))
      else $error("status bit took written value");

endmodule
`default_nettype wire

// ===== bench/reg_host.sv
// Host side model that issues single register accesses on the request port.
// Assumes the bench calls access from one thread, at falling edges only.
`timescale 1ns/100ps
`default_nettype none

module reg_host
   import charger_pkg::*;
(
   input wire logic i_mclk,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   output var reg_req_s o_req
);
   // Idle request port at time zero
   initial begin
      o_req = '0;
   end

   // Drive after a falling edge, hold across one rising edge, then take
   task automatic access(input logic w, input logic r, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic v);
      @(negedge i_mclk);
      o_req = '{wr: w, rd: r, addr: a, wdata: d};
      @(negedge i_mclk);
      q = i_rdata;
      v = i_rvalid;
      // Released lines show the inverse so stale values are never trusted
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule

`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the charger status and configuration registers.
// Assumes the host model drives the request port; core status from here.
`timescale 1ns/100ps
`default_nettype none

module tb
   import charger_pkg::*;
;
   logic i_mclk, i_rst_n, i_detect_done;
   reg_req_s req;
   core_status_s st;
   logic [4:0] fc;
   logic [7:0] o_reg_rdata;
   logic o_reg_rvalid, o_detect_start, o_timer_halfspeed, o_timer_disable;
   logic o_thermistor_enable;
   logic [11:0] o_charge_current_ma;
   logic [19:0] o_input_threshold_mv;
   logic [16:0] o_timer_limit_s;
   logic [12:0] o_boost_limit_ma;
   logic [7:0] rnd = 8'h0D;
   int bad_count = 0;
   int n_tests = 0;
   int red, det, code, half, sel, boost, ten, base;

   charger_status_config_regs dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_req(req), .i_status(st), .i_fast_charge_code(fc),
      .i_detect_done(i_detect_done), .o_reg_rdata(o_reg_rdata),
      .o_reg_rvalid(o_reg_rvalid), .o_detect_start(o_detect_start),
      .o_charge_current_ma(o_charge_current_ma),
      .o_input_threshold_mv(o_input_threshold_mv),
      .o_timer_halfspeed(o_timer_halfspeed),
      .o_timer_limit_s(o_timer_limit_s), .o_timer_disable(o_timer_disable),
      .o_boost_limit_ma(o_boost_limit_ma),
      .o_thermistor_enable(o_thermistor_enable));

   reg_host host_u (.i_mclk(i_mclk), .i_rdata(o_reg_rdata),
      .i_rvalid(o_reg_rvalid), .o_req(req));

   // Free running clock
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Expected register images from the model fields and live status
   function automatic logic [7:0] m05();
      return {st.min_system_mode_flag, st.input_regulation_active_flag,
         red[0], det[0], st.chip_disable_pin, code[2:0]};
   endfunction

   function automatic logic [7:0] m06();
      return {half[0], sel[1:0], boost[0], ten[0],
         ten[0] ? st.thermistor_fault_code : 2'h0, base[0]};
   endfunction

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("BAD t=%0t seen %0h expected %0h", $time, s, e);
      end
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Hold reset two cycles, check reset levels, reload model defaults
   task automatic rst();
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_mclk);
      check(o_reg_rdata, 0);
      check(o_charge_current_ma, 300);
      check(o_timer_limit_s, 75);
      check(o_boost_limit_ma, 4000);
      check(o_thermistor_enable, 1);
      red = 0;
      det = 0;
      code = 0;
      half = 1;
      sel = 0;
      boost = 1;
      ten = 1;
      base = 0;
      i_rst_n = 1'b1;
   endtask

   // Register write plus model update; status bits never change
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic v;
      host_u.access(1'b1, 1'b0, a, d, q, v);
      check(o_detect_start, a == 8'h05 && d[4]);
      check(v, 0);
      if (a == 8'h05) begin
         red = d[5];
         det = d[4];
         code = d[2:0];
      end else if (a == 8'h06) begin
         half = d[7];
         sel = d[6:5];
         boost = d[4];
         ten = d[3];
         base = d[0];
      end
   endtask

   // Register read compared against the model image
   task automatic rd(input logic [7:0] a);
      logic [7:0] q, e;
      logic v;
      e = a == 8'h05 ? m05() : a == 8'h06 ? m06() : 8'h00;
      rnd = lfsr(rnd);
      host_u.access(1'b0, 1'b1, a, rnd, q, v);
      check(v, 1);
      check(q, e);
   endtask

   // Derived core outputs after they have settled
   task automatic outs();
      int cur;
      repeat (2) @(negedge i_mclk);
      cur = 500 + fc * 100;
      if (cur > 3000) cur = 3000;
      if (red[0]) cur = 300;
      check(o_charge_current_ma, cur);
      check(o_input_threshold_mv,
         (base[0] ? 10100 : 4200) * (50 + code) / 50);
      check(o_timer_halfspeed, half[0] & (st.thermal_reg_active |
         st.input_regulation_active_flag |
         st.input_current_limit_active));
      check(o_timer_limit_s, sel == 0 ? 75 : sel == 1 ? 21600 : 32400);
      check(o_timer_disable, sel == 3);
      check(o_boost_limit_ma, boost[0] ? 4000 : 2000);
      check(o_thermistor_enable, ten[0]);
   endtask

   // Main sequence
   initial begin
      i_rst_n = 1'b0;
      st = 7'h5A;
      fc = 5'h0A;
      i_detect_done = 1'b0;
      rst();
      outs();
      rd(8'h05);
      rd(8'h06);
      // Every code and timer select in turn, with reduced current and detection bits left clear
      for (int i = 0; i < 8; i++) begin
         wr(8'h05, 8'hC8 | i[2:0]);
         wr(8'h06, {i[2], i[1:0], i[0], ~i[0], 2'h3, i[2] ^ i[1] ^ ~i[0]});
         outs();
         rd(8'h05);
         rd(8'h06);
      end
      // Random status, fast charge code, writes and unmapped accesses
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         st = rnd[6:0];
         rnd = lfsr(rnd);
         fc = rnd[4:0];
         rnd = lfsr(rnd);
         wr(rnd[0] ? 8'h05 : 8'h06, lfsr(rnd));
         wr({rnd[7:3], 3'h7}, ~rnd);
         outs();
         rd(8'h05);
         rd(8'h06);
         rd({rnd[4:0], 3'h7});
      end
      // Saturated code; detection start with ignored status bit writes
      st = 7'h25;
      fc = 5'h1F;
      wr(8'h05, 8'hD0);
      rd(8'h05);
      i_detect_done = 1'b1;
      @(negedge i_mclk);
      i_detect_done = 1'b0;
      det = 0;
      rd(8'h05);
      outs();
      // Reset in mid run restores defaults
      rst();
      outs();
      rd(8'h05);
      rd(8'h06);
      end_of_test();
   end

   // Watchdog against a hung run
   initial begin
      #100000;
      bad_count++;
      end_of_test();
   end
endmodule

`default_nettype wire
